// ---- design/cmd_decode_pkg.sv ----
// Purpose: constants for the serial flash command decoder
// Assumes: single-wire opcode byte, msb first, mode 0 sampling
// Notes: opcode values, address byte counts and frame widths
package cmd_decode_pkg;
  localparam logic [7:0] OP_READ = 8'h03;
  localparam logic [7:0] OP_READ_W = 8'h13;
  localparam logic [7:0] OP_FAST = 8'h0B;
  localparam logic [7:0] OP_FAST_W = 8'h0C;
  localparam logic [7:0] OP_DOR = 8'h3B;
  localparam logic [7:0] OP_DOR_W = 8'h3C;
  localparam logic [7:0] OP_QOR = 8'h6B;
  localparam logic [7:0] OP_QOR_W = 8'h6C;
  localparam logic [7:0] OP_DIOR = 8'hBB;
  localparam logic [7:0] OP_DIOR_W = 8'hBC;
  localparam logic [7:0] OP_QIOR = 8'hEB;
  localparam logic [7:0] OP_QIOR_W = 8'hEC;
  localparam logic [7:0] OP_DDR = 8'hED;
  localparam logic [7:0] OP_DDR_W = 8'hEE;
  localparam logic [7:0] OP_PP = 8'h02;
  localparam logic [7:0] OP_PP_W = 8'h12;
  localparam logic [7:0] OP_QPP = 8'h32;
  localparam logic [7:0] OP_QPP_W = 8'h34;
  localparam logic [7:0] OP_SE = 8'h20;
  localparam logic [7:0] OP_SE_W = 8'h21;
  localparam logic [7:0] OP_HBE = 8'h52;
  localparam logic [7:0] OP_HBE_W = 8'h53;
  localparam logic [7:0] OP_BE = 8'hD8;
  localparam logic [7:0] OP_BE_W = 8'hDC;
  localparam logic [7:0] OP_LRD = 8'h3D;
  localparam logic [7:0] OP_LRD_W = 8'hE0;
  localparam logic [7:0] OP_LCK = 8'h36;
  localparam logic [7:0] OP_LCK_W = 8'hE1;
  localparam logic [7:0] OP_ULK = 8'h39;
  localparam logic [7:0] OP_ULK_W = 8'hE2;
  localparam logic [7:0] OP_PPS = 8'hFB;
  localparam logic [7:0] OP_PPS_W = 8'hE3;
  localparam logic [7:0] OP_PARAM_RD = 8'h5A;
  localparam logic [7:0] OP_ANY_RD = 8'h65;
  localparam logic [7:0] OP_ANY_WR = 8'h71;
  localparam logic [7:0] OP_SEC_ER = 8'h44;
  localparam logic [7:0] OP_SEC_PG = 8'h42;
  localparam logic [7:0] OP_SEC_RD = 8'h48;
  localparam logic [7:0] OP_ID_RD = 8'h9F;
  localparam logic [7:0] OP_REG_WR = 8'h01;
  localparam logic [7:0] OP_WEN_NV = 8'h06;
  localparam logic [7:0] OP_WEN_V = 8'h50;
  localparam logic [7:0] OP_WIDE_EN = 8'hB7;
  localparam logic [7:0] OP_WIDE_EX = 8'hE9;
  localparam logic [7:0] OP_TRN_RD = 8'h41;
  localparam logic [7:0] OP_TRN_NV = 8'h43;
  localparam logic [7:0] OP_TRN_V = 8'h4A;
  localparam logic [2:0] ADDR_NONE = 3'h0;
  localparam logic [2:0] ADDR_NARROW = 3'h3;
  localparam logic [2:0] ADDR_WIDE = 3'h4;
  localparam int BYTE_BITS = 8;
  localparam logic [2:0] BIT_LAST = 3'h7;
  typedef enum logic [3:0] {
    CLS_NONE, CLS_READ, CLS_PROGRAM, CLS_ERASE, CLS_PARAM, CLS_REG_ACCESS,
    CLS_SECURITY, CLS_LOCK, CLS_ID, CLS_WRITE_EN, CLS_MODE, CLS_TRAINING
  } class_type;
endpackage

// ---- design/flash_command_address_decoder.sv ----
// Purpose: opcode capture and address length selection of a serial flash
// Assumes: host link clock sampled by i_clk, well below half its rate
// Notes: one-wire opcode shift; four-wire flag supplied from outside
// Operation
// - dedicated opcodes always take four address bytes
// - mode bit set gives legacy commands four bytes
// - any reset reloads mode bit from default
// - legacy opcodes follow the address mode bit
// - pointer protect under both opcodes
// - mode enter and exit, valid four-wire
// - identification read, no address, four-wire valid
// - parameter read, three or four bytes
// - register write opcode, no address
// - nonvolatile write enable, no address
// - volatile write enable, no address
// - training pattern read, no address
// - training nonvolatile program, no address
// - training volatile write, no address
// - drop command ending off byte boundary
`timescale 1ns/1ns
`default_nettype none
module flash_command_address_decoder (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_sclk,
  input wire logic i_cs_n,
  input wire logic i_si,
  input wire logic i_sw_reset,
  input wire logic i_addr_len_default_bit,
  input wire logic i_four_wire_command_mode,
  output logic o_opcode_valid,
  output logic [7:0] o_opcode,
  output cmd_decode_pkg::class_type o_cmd_class,
  output logic [2:0] o_addr_bytes,
  output logic o_cmd_legal,
  output logic o_cmd_done,
  output logic o_cmd_discard,
  output logic o_addr_len_volatile_bit
);
  import cmd_decode_pkg::*;

  // ----------------------------------------
  // input synchronisers
  // ----------------------------------------
  logic [1:0] sclk_sync_q, cs_sync_q, si_sync_q, rst_sync_q;
  logic [1:0] sclk_sync_d, cs_sync_d, si_sync_d, rst_sync_d;
  logic sclk_prev_q, cs_prev_q;
  logic sclk_prev_d, cs_prev_d;
  // only the second stage feeds logic
  always_comb begin
    sclk_sync_d = {sclk_sync_q[0], i_sclk};
    cs_sync_d = {cs_sync_q[0], i_cs_n};
    si_sync_d = {si_sync_q[0], i_si};
    rst_sync_d = {rst_sync_q[0], i_sw_reset};
    sclk_prev_d = sclk_sync_q[1];
    cs_prev_d = cs_sync_q[1];
  end

  // reset to idle pin levels, so no false edge after reset
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      sclk_sync_q <= 2'h0;
      cs_sync_q <= 2'h3;
      si_sync_q <= 2'h0;
      rst_sync_q <= 2'h0;
      sclk_prev_q <= 1'b0;
      cs_prev_q <= 1'b1;
    end else begin
      sclk_sync_q <= sclk_sync_d;
      cs_sync_q <= cs_sync_d;
      si_sync_q <= si_sync_d;
      rst_sync_q <= rst_sync_d;
      sclk_prev_q <= sclk_prev_d;
      cs_prev_q <= cs_prev_d;
    end
  end
  logic sclk_rise, cs_fall, cs_rise, selected, sw_rst;
  assign sclk_rise = sclk_sync_q[1] & ~sclk_prev_q;
  assign cs_fall = cs_prev_q & ~cs_sync_q[1];
  assign cs_rise = ~cs_prev_q & cs_sync_q[1];
  assign selected = ~cs_sync_q[1];
  assign sw_rst = rst_sync_q[1];

  // ----------------------------------------
  // opcode classification
  // ----------------------------------------
  function automatic logic is_wide_op(input logic [7:0] op);
    case (op)
      OP_READ_W, OP_FAST_W, OP_DOR_W, OP_QOR_W, OP_DIOR_W, OP_QIOR_W, OP_DDR_W,
      OP_PP_W, OP_QPP_W, OP_SE_W, OP_HBE_W, OP_BE_W, OP_LRD_W, OP_LCK_W,
      OP_ULK_W, OP_PPS_W: is_wide_op = 1'b1;
      default: is_wide_op = 1'b0;
    endcase
  endfunction

  function automatic logic is_mode_op(input logic [7:0] op);
    case (op)
      OP_PARAM_RD, OP_READ, OP_FAST, OP_DOR, OP_QOR, OP_DIOR, OP_QIOR, OP_DDR,
      OP_PP, OP_QPP, OP_SE, OP_HBE, OP_BE, OP_ANY_RD, OP_ANY_WR, OP_SEC_ER,
      OP_SEC_PG, OP_SEC_RD, OP_LRD, OP_LCK, OP_ULK, OP_PPS: is_mode_op = 1'b1;
      default: is_mode_op = 1'b0;
    endcase
  endfunction

  function automatic class_type op_class(input logic [7:0] op);
    case (op)
      OP_READ, OP_READ_W, OP_FAST, OP_FAST_W, OP_DOR, OP_DOR_W, OP_QOR, OP_QOR_W,
      OP_DIOR, OP_DIOR_W, OP_QIOR, OP_QIOR_W, OP_DDR, OP_DDR_W: op_class = CLS_READ;
      OP_PP, OP_PP_W, OP_QPP, OP_QPP_W: op_class = CLS_PROGRAM;
      OP_SE, OP_SE_W, OP_HBE, OP_HBE_W, OP_BE, OP_BE_W: op_class = CLS_ERASE;
      OP_PARAM_RD: op_class = CLS_PARAM;
      OP_ANY_RD, OP_ANY_WR, OP_REG_WR: op_class = CLS_REG_ACCESS;
      OP_SEC_ER, OP_SEC_PG, OP_SEC_RD: op_class = CLS_SECURITY;
      OP_LRD, OP_LRD_W, OP_LCK, OP_LCK_W, OP_ULK, OP_ULK_W, OP_PPS, OP_PPS_W:
        op_class = CLS_LOCK;
      OP_ID_RD: op_class = CLS_ID;
      OP_WEN_NV, OP_WEN_V: op_class = CLS_WRITE_EN;
      OP_WIDE_EN, OP_WIDE_EX: op_class = CLS_MODE;
      OP_TRN_RD, OP_TRN_NV, OP_TRN_V: op_class = CLS_TRAINING;
      default: op_class = CLS_NONE;
    endcase
  endfunction

  // commands that may not be issued in four-wire mode
  function automatic logic single_wire_only(input logic [7:0] op);
    case (op)
      OP_READ, OP_READ_W, OP_FAST, OP_FAST_W, OP_DOR, OP_DOR_W, OP_QOR, OP_QOR_W,
      OP_DIOR, OP_DIOR_W, OP_QPP, OP_QPP_W: single_wire_only = 1'b1;
      default: single_wire_only = 1'b0;
    endcase
  endfunction

  // ----------------------------------------
  // frame state
  // ----------------------------------------
  typedef enum logic [1:0] {ST_IDLE, ST_OPCODE, ST_BODY} frame_type;
  frame_type state_q, state_d;
  logic [2:0] bit_cnt_q, bit_cnt_d;
  logic [7:0] shift_q, shift_d;
  logic [7:0] opcode_q, opcode_d;
  class_type class_q, class_d;
  logic [2:0] addr_bytes_q, addr_bytes_d;
  logic legal_q, legal_d;
  logic valid_q, valid_d;
  logic done_q, done_d;
  logic discard_q, discard_d;
  logic mode_q, mode_d;
  logic reload_q, reload_d;
  logic [7:0] op_next;
  class_type cls_next;

  always_comb begin
    state_d = state_q;
    bit_cnt_d = bit_cnt_q;
    shift_d = shift_q;
    opcode_d = opcode_q;
    class_d = class_q;
    addr_bytes_d = addr_bytes_q;
    legal_d = legal_q;
    valid_d = 1'b0;
    done_d = 1'b0;
    discard_d = 1'b0;
    op_next = {shift_q[6:0], si_sync_q[1]};
    cls_next = op_class(op_next);
    case (state_q)
      ST_IDLE: begin
        if (cs_fall) begin
          state_d = ST_OPCODE;
          bit_cnt_d = 3'h0;
        end
      end
      ST_OPCODE: begin
        if (cs_rise) begin
          state_d = ST_IDLE;
          discard_d = 1'b1;
        end else if (sclk_rise) begin
          shift_d = op_next;
          bit_cnt_d = bit_cnt_q + 3'h1;
          if (bit_cnt_q == BIT_LAST) begin
            state_d = ST_BODY;
            opcode_d = op_next;
            class_d = cls_next;
            valid_d = 1'b1;
            legal_d = (cls_next != CLS_NONE) &&
                      !(i_four_wire_command_mode && single_wire_only(op_next));
            if (is_wide_op(op_next)) begin
              addr_bytes_d = ADDR_WIDE;
            end else if (is_mode_op(op_next)) begin
              addr_bytes_d = mode_q ? ADDR_WIDE : ADDR_NARROW;
            end else begin
              addr_bytes_d = ADDR_NONE;
            end
          end
        end
      end
      ST_BODY: begin
        if (cs_rise) begin
          state_d = ST_IDLE;
          if (bit_cnt_q != 3'h0) begin
            discard_d = 1'b1;
          end else begin
            // only a known, allowed opcode completes
            done_d = legal_q;
          end
        end else if (sclk_rise) begin
          bit_cnt_d = bit_cnt_q + 3'h1;
        end
      end
      default: state_d = ST_IDLE;
    endcase
    if (!selected && state_q == ST_IDLE) begin
      bit_cnt_d = 3'h0;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      state_q <= ST_IDLE;
      bit_cnt_q <= 3'h0;
      shift_q <= 8'h00;
      opcode_q <= 8'h00;
      class_q <= CLS_NONE;
      addr_bytes_q <= ADDR_NONE;
      legal_q <= 1'b0;
      valid_q <= 1'b0;
      done_q <= 1'b0;
      discard_q <= 1'b0;
    end else begin
      state_q <= state_d;
      bit_cnt_q <= bit_cnt_d;
      shift_q <= shift_d;
      opcode_q <= opcode_d;
      class_q <= class_d;
      addr_bytes_q <= addr_bytes_d;
      legal_q <= legal_d;
      valid_q <= valid_d;
      done_q <= done_d;
      discard_q <= discard_d;
    end
  end

  // ----------------------------------------
  // address length mode bit
  // ----------------------------------------
  // mode commands act only when a clean frame closes
  logic wide_enter, wide_exit;
  assign wide_enter = done_d && (opcode_q == OP_WIDE_EN);
  assign wide_exit = done_d && (opcode_q == OP_WIDE_EX);

  always_comb begin
    mode_d = mode_q;
    reload_d = sw_rst;
    if (wide_enter) begin
      mode_d = 1'b1;
    end else if (wide_exit) begin
      mode_d = 1'b0;
    end
    // reload outranks a mode command in the same cycle
    if (reload_q) begin
      mode_d = i_addr_len_default_bit;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      mode_q <= 1'b0;
      reload_q <= 1'b1;
    end else begin
      mode_q <= mode_d;
      reload_q <= reload_d;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign o_opcode_valid = valid_q;
  assign o_opcode = opcode_q;
  assign o_cmd_class = class_q;
  assign o_addr_bytes = addr_bytes_q;
  assign o_cmd_legal = legal_q;
  assign o_cmd_done = done_q;
  assign o_cmd_discard = discard_q;
  assign o_addr_len_volatile_bit = mode_q;
endmodule
`default_nettype wire

// ---- tb/flash_command_address_decoder_props.sv ----
// Purpose: port-level checks of the command decoder
// Assumes: single clock domain, async active high reset
// Notes: attached by bind at the foot of this file
`timescale 1ns/1ns
`default_nettype none
module decoder_checker import cmd_decode_pkg::*; (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_sw_reset,
  input wire logic i_addr_len_default_bit,
  input wire logic i_four_wire_command_mode,
  input wire logic o_opcode_valid,
  input wire logic [7:0] o_opcode,
  input wire logic [2:0] o_addr_bytes,
  input wire logic o_cmd_legal,
  input wire logic o_cmd_done,
  input wire logic o_cmd_discard,
  input wire logic o_addr_len_volatile_bit
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  a_wide_count: assert property (o_opcode_valid && o_opcode inside {8'h13, 8'h0C, 8'hDC, 8'hE3}
    |-> o_addr_bytes == ADDR_WIDE) else $error("wide opcode count wrong");
  a_legacy_count: assert property (o_opcode_valid && o_cmd_legal &&
    o_opcode inside {8'h03, 8'h02, 8'h20, 8'hFB, 8'h5A}
    |-> o_addr_bytes == (o_addr_len_volatile_bit ? ADDR_WIDE : ADDR_NARROW)) else $error("legacy count wrong");
  a_no_addr: assert property (o_opcode_valid &&
    o_opcode inside {8'h9F, 8'h01, 8'h06, 8'h50, 8'h41, 8'h43, 8'h4A, 8'hB7, 8'hE9}
    |-> o_cmd_legal && o_addr_bytes == ADDR_NONE) else $error("address-free opcode wrong");
  a_quad_refuse: assert property (o_opcode_valid && i_four_wire_command_mode &&
    o_opcode inside {8'h03, 8'h13, 8'h0B, 8'h0C} |-> !o_cmd_legal) else $error("single-wire op accepted");
  a_valid_pulse: assert property (o_opcode_valid |=> !o_opcode_valid) else $error("valid longer than one cycle");
  a_end_exclusive: assert property (o_cmd_discard |-> !o_cmd_done ##1 !o_cmd_done) else $error("done on discard");
  a_enter_mode: assert property (o_cmd_done && o_opcode == 8'hB7
    |-> ##[0:1] o_addr_len_volatile_bit) else $error("mode enter missed");
  a_exit_mode: assert property (o_cmd_done && o_opcode == 8'hE9
    |-> ##[0:1] !o_addr_len_volatile_bit) else $error("mode exit missed");
  a_sw_reload: assert property ($rose(i_sw_reset)
    |-> ##[2:6] o_addr_len_volatile_bit == i_addr_len_default_bit) else $error("mode not reloaded");
endmodule
bind flash_command_address_decoder decoder_checker u_chk (.i_clk(i_clk), .i_rst(i_rst),
  .i_sw_reset(i_sw_reset), .i_addr_len_default_bit(i_addr_len_default_bit),
  .i_four_wire_command_mode(i_four_wire_command_mode), .o_opcode_valid(o_opcode_valid),
  .o_opcode(o_opcode), .o_addr_bytes(o_addr_bytes), .o_cmd_legal(o_cmd_legal),
  .o_cmd_done(o_cmd_done), .o_cmd_discard(o_cmd_discard), .o_addr_len_volatile_bit(o_addr_len_volatile_bit));
`default_nettype wire

// ---- tb/host_model.sv ----
// Purpose: host controller model driving select, serial clock and data
// Assumes: mode 0, link clock 400 ns, stands still outside frames
// Notes: all changes made on falling edges of the system clock
`timescale 1ns/1ns
`default_nettype none
module host_model (
  input wire logic i_clk,
  output logic o_sclk,
  output logic o_cs_n,
  output logic o_si
);
  initial begin
    o_sclk = 1'b0;
    o_cs_n = 1'b1;
    o_si = 1'b1;
  end
  // half link period, 2.5 MHz well under the rated rate
  task automatic half();
    repeat (4) @(negedge i_clk);
  endtask
  // opcode msb first, then extra body bits of zero
  task automatic frame(input logic [7:0] op, input int extra);
    int i;
    @(negedge i_clk);
    o_cs_n = 1'b0;
    for (i = 0; i < 8 + extra; i++) begin
      o_si = (i < 8) ? op[7 - i] : 1'b0;
      half();
      o_sclk = 1'b1;
      half();
      o_sclk = 1'b0;
    end
    half();
    o_cs_n = 1'b1;
    // released line must not keep the last bit
    o_si = ~o_si;
    half();
    half();
  endtask
endmodule
`default_nettype wire

// ---- tb/tb_top.sv ----
// Purpose: self-checking bench of the command decoder
// Assumes: host model makes every frame
// Notes: outputs captured at each pulse, judged after the frame
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import cmd_decode_pkg::*;
  logic i_clk, i_rst, i_sw_reset, dflt, four, sclk, cs_n, si;
  logic o_opcode_valid, o_cmd_legal, o_cmd_done, o_cmd_discard, mode, cap_legal;
  logic [7:0] o_opcode, cap_op;
  logic [2:0] o_addr_bytes, cap_addr;
  class_type o_cmd_class, cap_cls;
  int n_fail = 0, samples_checked = 0, n_done = 0, n_disc = 0;
  flash_command_address_decoder dut (.i_clk(i_clk), .i_rst(i_rst), .i_sclk(sclk), .i_cs_n(cs_n),
    .i_si(si), .i_sw_reset(i_sw_reset), .i_addr_len_default_bit(dflt), .i_four_wire_command_mode(four),
    .o_opcode_valid(o_opcode_valid), .o_opcode(o_opcode), .o_cmd_class(o_cmd_class),
    .o_addr_bytes(o_addr_bytes), .o_cmd_legal(o_cmd_legal), .o_cmd_done(o_cmd_done),
    .o_cmd_discard(o_cmd_discard), .o_addr_len_volatile_bit(mode));
  host_model host (.i_clk(i_clk), .o_sclk(sclk), .o_cs_n(cs_n), .o_si(si));
  initial begin
    i_clk = 1'b0;
    forever #25 i_clk = ~i_clk;
  end
  always @(posedge i_clk) begin
    if (o_opcode_valid === 1'b1) begin
      cap_op <= o_opcode;
      cap_addr <= o_addr_bytes;
      cap_legal <= o_cmd_legal;
      cap_cls <= o_cmd_class;
    end
    if (o_cmd_done === 1'b1) n_done <= n_done + 1;
    if (o_cmd_discard === 1'b1) n_disc <= n_disc + 1;
  end
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // expected class of each opcode the scenarios send
  function automatic class_type cls_of(input logic [7:0] op);
    case (op)
      8'h03, 8'h13, 8'h0C: cls_of = CLS_READ;
      8'h02: cls_of = CLS_PROGRAM;
      8'h20, 8'h21, 8'hDC: cls_of = CLS_ERASE;
      8'hFB, 8'hE3: cls_of = CLS_LOCK;
      8'h5A: cls_of = CLS_PARAM;
      8'h65, 8'h01: cls_of = CLS_REG_ACCESS;
      8'h44: cls_of = CLS_SECURITY;
      8'h9F: cls_of = CLS_ID;
      8'h06, 8'h50: cls_of = CLS_WRITE_EN;
      8'hB7, 8'hE9: cls_of = CLS_MODE;
      8'h41, 8'h43, 8'h4A: cls_of = CLS_TRAINING;
      default: cls_of = CLS_NONE;
    endcase
  endfunction
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic run(input logic [7:0] op, input int extra, input logic [2:0] ab, input logic lg, input logic dn);
    int d0, x0;
    d0 = n_done;
    x0 = n_disc;
    cap_op = ~op;
    cap_addr = ~ab;
    cap_legal = ~lg;
    cap_cls = (cls_of(op) == CLS_NONE) ? CLS_ID : CLS_NONE;
    host.frame(op, extra);
    chk("opcode", cap_op, op);
    chk("class", 8'(cap_cls), 8'(cls_of(op)));
    if (lg) chk("addr_bytes", 8'(cap_addr), 8'(ab));
    chk("legal", 8'(cap_legal), 8'(lg));
    chk("done", 8'(n_done - d0), 8'(dn));
    chk("discard", 8'(n_disc - x0), 8'(extra % 8 != 0));
  endtask
  task automatic t_addr_len(input logic m);
    logic [7:0] wide[5] = '{8'h13, 8'h0C, 8'hDC, 8'hE3, 8'h21};
    logic [7:0] leg[7] = '{8'h03, 8'h02, 8'h20, 8'hFB, 8'h5A, 8'h65, 8'h44};
    logic [7:0] none[7] = '{8'h9F, 8'h01, 8'h06, 8'h50, 8'h41, 8'h43, 8'h4A};
    foreach (wide[i]) run(wide[i], 0, ADDR_WIDE, 1'b1, 1'b1);
    foreach (leg[i]) run(leg[i], 0, m ? ADDR_WIDE : ADDR_NARROW, 1'b1, 1'b1);
    foreach (none[i]) run(none[i], 0, ADDR_NONE, 1'b1, 1'b1);
    $display("test addr_len mode %0d done", m);
  endtask
  task automatic t_mode();
    run(8'hB7, 0, ADDR_NONE, 1'b1, 1'b1);
    chk("mode", 8'(mode), 8'h01);
    t_addr_len(1'b1);
    run(8'hE9, 0, ADDR_NONE, 1'b1, 1'b1);
    chk("mode", 8'(mode), 8'h00);
    $display("test mode done");
  endtask
  task automatic t_discard();
    run(8'hB7, 3, ADDR_NONE, 1'b1, 1'b0);
    chk("mode", 8'(mode), 8'h00);
    run(8'h03, 26, ADDR_NARROW, 1'b1, 1'b0);
    run(8'h03, 24, ADDR_NARROW, 1'b1, 1'b1);
    $display("test discard done");
  endtask
  task automatic t_four_wire();
    @(negedge i_clk) four = 1'b1;
    run(8'h03, 0, ADDR_NARROW, 1'b0, 1'b0);
    run(8'h0C, 0, ADDR_WIDE, 1'b0, 1'b0);
    run(8'h9F, 0, ADDR_NONE, 1'b1, 1'b1);
    run(8'hB7, 0, ADDR_NONE, 1'b1, 1'b1);
    run(8'hE9, 0, ADDR_NONE, 1'b1, 1'b1);
    run(8'h5A, 0, ADDR_NARROW, 1'b1, 1'b1);
    @(negedge i_clk) four = 1'b0;
    run(8'hFF, 0, ADDR_NONE, 1'b0, 1'b0);
    $display("test four_wire done");
  endtask
  task automatic t_sw_reset(input logic d);
    @(negedge i_clk) dflt = d;
    @(negedge i_clk) i_sw_reset = 1'b1;
    repeat (2) @(negedge i_clk);
    i_sw_reset = 1'b0;
    repeat (8) @(negedge i_clk);
    chk("mode", 8'(mode), 8'(d));
    $display("test sw_reset %0d done", d);
  endtask
  task automatic t_hw_reset();
    @(negedge i_clk) dflt = 1'b1;
    @(negedge i_clk) i_rst = 1'b1;
    repeat (4) @(negedge i_clk);
    i_rst = 1'b0;
    repeat (3) @(negedge i_clk);
    chk("mode", 8'(mode), 8'h01);
    run(8'h03, 0, ADDR_WIDE, 1'b1, 1'b1);
    $display("test hw_reset done");
  endtask
  initial begin
    i_rst = 1'b1;
    i_sw_reset = 1'b0;
    dflt = 1'b0;
    four = 1'b0;
    repeat (8) @(negedge i_clk);
    i_rst = 1'b0;
    repeat (3) @(negedge i_clk);
    chk("mode", 8'(mode), 8'h00);
    t_addr_len(1'b0);
    t_mode();
    t_discard();
    t_four_wire();
    t_sw_reset(1'b1);
    run(8'h20, 0, ADDR_WIDE, 1'b1, 1'b1);
    t_sw_reset(1'b0);
    t_hw_reset();
    give_verdict();
  end
  initial begin
    repeat (20000) @(posedge i_clk);
    n_fail++;
    give_verdict();
  end
endmodule
`default_nettype wire
